// File: src/idcp_pkg.sv
package idcp_pkg;

   // register byte addresses
   localparam logic [31:0] DATA_CMD_ADDR = 32'h5000_1310;
   localparam logic [31:0] CTRL_ADDR     = 32'h5000_1340;
   localparam logic [31:0] EVENT_ADDR    = 32'h5000_1344;
   localparam logic [31:0] MASK_ADDR     = 32'h5000_1348;
   localparam logic [31:0] STATE_ADDR    = 32'h5000_134c;

   // command word fields
   localparam int CMD_RESTART_BIT = 10;
   localparam int CMD_STOP_BIT    = 9;
   localparam int CMD_READ_BIT    = 8;
   localparam logic [15:0] DATA_CMD_RESET = 16'h0000;

   // control register fields
   localparam int CTRL_RESTART_ALLOW_BIT = 0;
   localparam int CTRL_MASTER_BIT        = 1;
   localparam int CTRL_GC_SPECIAL_BIT    = 2;
   localparam logic [2:0] CTRL_RESET     = 3'h3;

   // raw event status / mask fields
   localparam int EV_RX_UNDER  = 0;
   localparam int EV_RX_OVER   = 1;
   localparam int EV_RX_FULL   = 2;
   localparam int EV_TX_OVER   = 3;
   localparam int EV_TX_EMPTY  = 4;
   localparam int EV_READ_REQ  = 5;
   localparam int EV_TX_ABORT  = 6;
   localparam int EV_STOP_DONE = 7;
   localparam logic [7:0] EVENT_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET  = 8'h00;

   // state register fields
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_STALL_BIT  = 1;
   localparam int ST_TXLVL_LSB  = 8;
   localparam int ST_RXLVL_LSB  = 16;

   typedef struct packed {
      logic       restart;
      logic       stop;
      logic       rd;
      logic [7:0] byteValue;
   } idcp_cmd_t;

   typedef enum logic [2:0] {
      OP_START   = 3'b000,
      OP_RESTART = 3'b001,
      OP_STOP    = 3'b010,
      OP_WRITE   = 3'b011,
      OP_READ    = 3'b100
   } idcp_op_t;

   typedef struct packed {
      logic       valid;
      idcp_op_t   code;
      logic [7:0] data;
   } idcp_busop_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WAIT = 2'b01
   } idcp_seq_t;

endpackage : idcp_pkg

// File: src/idcp_data_command_port.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Contract
// R1 - restart bit set: repeated start if allowed, else stop then start, before the byte
// R2 - restart bit clear: repeated start only on direction change if allowed, else stop+start
// R3 - stop bit set: stop follows the byte even if more commands wait
// R4 - after a stop with commands still queued, begin a new transfer with start
// R5 - stop bit clear with commands queued: keep transfer open, follow read select bits
// R6 - stop bit clear and queue empty: hold clock low until a command arrives
// R7 - read select 1 means read, 0 write; steers direction only as master
// R8 - each command write queues one entry, marked read or write by read select
// R9 - read command after general call with special bit set raises transmit abort
// R10 - read command written after a read request event raises transmit abort
// R11 - read command colliding with remote read request is dropped, abort raised
// R12 - as slave transmitter, a write command's byte goes to the remote master
// R13 - as slave receiver, received bytes are queued without any command
// R14 - data byte of a read command is ignored
// R15 - reading the command location returns a received byte in bits 7:0
// R16 - each read pops the receive queue; upper bits read zero
module idcp_data_command_port
   import idcp_pkg::*;
#(
   parameter int TX_DEPTH = 4,
   parameter int RX_DEPTH = 4
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output      logic [31:0] wb_dat_o,
   output      logic        wb_ack_o,
   output      logic        irq,
   output      idcp_busop_t busOp,
   input  wire logic        opDone,
   input  wire logic [7:0]  opRxByte,
   output      logic        sclHold,
   input  wire logic        slaveReadReq,
   output      logic        slaveTxValid,
   output      logic [7:0]  slaveTxData,
   input  wire logic        slaveTxTaken,
   input  wire logic        slaveRxValid,
   input  wire logic [7:0]  slaveRxByte
);

   localparam int TAW = $clog2(TX_DEPTH);
   localparam int RAW = $clog2(RX_DEPTH);

   idcp_cmd_t        txMem [TX_DEPTH];
   logic [7:0]       rxMem [RX_DEPTH];
   logic [TAW-1:0]   txRd;
   logic [TAW-1:0]   txWr;
   logic [TAW:0]     txCount;
   logic [RAW-1:0]   rxRd;
   logic [RAW-1:0]   rxWr;
   logic [RAW:0]     rxCount;
   logic [2:0]       ctrl;
   logic [7:0]       events;
   logic [7:0]       mask;
   idcp_seq_t        seq;
   logic             active;
   logic             afterCond;
   logic             prevRd;
   logic             curStop;
   logic             readReqSeen;

   logic             busReq;
   logic             wrAccess;
   logic             rdAccess;
   logic             cmdWrite;
   logic             cmdRead;
   logic             txFull;
   logic             txAvail;
   logic             rxFull;
   logic             rxAvail;
   idcp_cmd_t        head;
   idcp_cmd_t        newCmd;
   logic             dropRead;
   logic             txPush;
   logic             txPop;
   logic             masterPop;
   logic             gcAbort;
   logic             slavePop;
   logic             rxPush;
   logic [7:0]       rxPushByte;
   logic             rxPop;
   logic             decide;
   logic             needCond;
   logic [7:0]       next_events;
   logic [31:0]      next_rdata;

   // single-cycle classic access: request is taken in the cycle before ack rises
   assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wrAccess = busReq && wb_we_i;
   assign rdAccess = busReq && !wb_we_i;
   assign cmdWrite = wrAccess && wb_adr_i == DATA_CMD_ADDR && wb_sel_i[1:0] == 2'h3;
   assign cmdRead  = rdAccess && wb_adr_i == DATA_CMD_ADDR;

   assign txFull  = txCount == (TAW+1)'(TX_DEPTH);
   assign txAvail = txCount != '0;
   assign rxFull  = rxCount == (RAW+1)'(RX_DEPTH);
   assign rxAvail = rxCount != '0;
   assign head    = txMem[txRd];

   // bits above the restart bit are reserved and never stored
   assign newCmd = '{restart:   wb_dat_i[CMD_RESTART_BIT],
                     stop:      wb_dat_i[CMD_STOP_BIT],
                     rd:        wb_dat_i[CMD_READ_BIT],
                     byteValue: wb_dat_i[7:0]};

   // a read command is refused while a remote master is, or was, reading us
   // a refused read never reaches the queue, so the tx level shows software it was dropped
   assign dropRead = cmdWrite && newCmd.rd && (slaveReadReq || readReqSeen); // [R10] [R11]
   assign txPush   = cmdWrite && !dropRead && !txFull; // [R8]

   // master sequencer only runs when the bus is not owned by a remote read
   assign decide    = seq == SEQ_IDLE && ctrl[CTRL_MASTER_BIT] && txAvail && !slaveReadReq; // [R7]
   assign gcAbort   = decide && head.rd && ctrl[CTRL_GC_SPECIAL_BIT] && !afterCond; // [R9]
   assign needCond  = !active || (!afterCond && (head.restart || head.rd != prevRd)); // [R1] [R2]
   assign masterPop = decide && !gcAbort && !needCond;
   assign slavePop  = slaveTxValid && slaveTxTaken; // [R12]
   assign txPop     = masterPop || gcAbort || slavePop;

   // master reads win over slave receive; both cannot own the bus at once
   assign rxPush     = (seq == SEQ_WAIT && opDone && busOp.code == OP_READ) || slaveRxValid; // [R13]
   assign rxPushByte = (seq == SEQ_WAIT && opDone && busOp.code == OP_READ) ? opRxByte : slaveRxByte;
   assign rxPop      = cmdRead && rxAvail; // [R16]

   // pointers wrap by overflow, so both depths must be powers of two
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         txWr    <= '0;
         txRd    <= '0;
         txCount <= '0;
      end else begin
         if (txPush) begin
            txMem[txWr] <= newCmd;
            txWr        <= TAW'(txWr + 1'b1);
         end
         if (txPop) begin
            txRd <= TAW'(txRd + 1'b1);
         end
         txCount <= (TAW+1)'(txCount + txPush - txPop);
      end
   end

   // a byte that meets a full queue is dropped; only the overflow flag remembers it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxWr    <= '0;
         rxRd    <= '0;
         rxCount <= '0;
      end else begin
         if (rxPush && !rxFull) begin
            rxMem[rxWr] <= rxPushByte;
            rxWr        <= RAW'(rxWr + 1'b1);
         end
         if (rxPop) begin
            rxRd <= RAW'(rxRd + 1'b1); // [R16]
         end
         rxCount <= (RAW+1)'(rxCount + (rxPush && !rxFull) - rxPop);
      end
   end

   // byte-level sequencer toward the bit engine
   // one byte or condition is in flight at a time; the engine's done pulse ends it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         seq       <= SEQ_IDLE;
         busOp     <= '{valid: 1'b0, code: OP_START, data: 8'h00};
         active    <= 1'b0;
         afterCond <= 1'b0;
         prevRd    <= 1'b0;
         curStop   <= 1'b0;
      end else begin
         case (seq)
            SEQ_IDLE: begin
               if (decide && !gcAbort) begin
                  seq         <= SEQ_WAIT;
                  busOp.valid <= 1'b1;
                  busOp.data  <= 8'h00;
                  if (!active) begin
                     busOp.code <= OP_START; // [R4]
                  end else if (needCond) begin
                     // without repeated starts the condition becomes stop, then a fresh start
                     busOp.code <= ctrl[CTRL_RESTART_ALLOW_BIT] ? OP_RESTART : OP_STOP; // [R1] [R2]
                  end else begin
                     busOp.code <= head.rd ? OP_READ : OP_WRITE; // [R5] [R7]
                     busOp.data <= head.rd ? 8'h00 : head.byteValue; // [R14]
                     prevRd     <= head.rd;
                     curStop    <= head.stop;
                  end
               end
            end
            SEQ_WAIT: begin
               if (opDone) begin
                  case (busOp.code)
                     OP_START, OP_RESTART: begin
                        afterCond   <= 1'b1;
                        active      <= 1'b1;
                        seq         <= SEQ_IDLE;
                        busOp.valid <= 1'b0;
                     end
                     OP_STOP: begin
                        active      <= 1'b0;
                        afterCond   <= 1'b0;
                        seq         <= SEQ_IDLE;
                        busOp.valid <= 1'b0;
                     end
                     OP_WRITE, OP_READ: begin
                        afterCond <= 1'b0;
                        if (curStop) begin
                           busOp.code <= OP_STOP; // [R3]
                           busOp.data <= 8'h00;
                        end else begin
                           seq         <= SEQ_IDLE;
                           busOp.valid <= 1'b0;
                        end
                     end
                     default: begin
                        seq         <= SEQ_IDLE;
                        busOp.valid <= 1'b0;
                     end
                  endcase
               end
            end
            default: begin
               seq         <= SEQ_IDLE;
               busOp.valid <= 1'b0;
            end
         endcase
      end
   end

   // clock is stretched whenever an open transfer has nothing queued and nothing in flight
   // a byte popped this cycle is still to be sent, so only an already empty queue stalls;
   // this costs one cycle before the stall flag rises
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sclHold <= 1'b0;
      end else begin
         sclHold <= active && seq == SEQ_IDLE && !txAvail && !txPush; // [R6]
      end
   end

   // slave transmitter: only write entries are offered to the remote master
   // the offer drops for one cycle after a pop so that the next head can settle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         slaveTxValid <= 1'b0;
         slaveTxData  <= 8'h00;
      end else begin
         slaveTxValid <= slaveReadReq && txAvail && !head.rd && !slavePop; // [R12]
         slaveTxData  <= head.byteValue;
      end
   end

   // read request stays remembered while it is raised and until software clears its event bit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         readReqSeen <= 1'b0;
      end else begin
         readReqSeen <= slaveReadReq || next_events[EV_READ_REQ];
      end
   end

   // status bits are sticky: only a write of one clears them
   always_comb begin
      next_events = events;
      if (wrAccess && wb_adr_i == EVENT_ADDR && wb_sel_i[0]) begin
         next_events = events & ~wb_dat_i[7:0];
      end
      // hardware sets win over a same-cycle software clear
      if (cmdRead && !rxAvail) next_events[EV_RX_UNDER] = 1'b1;
      if (rxPush && rxFull) next_events[EV_RX_OVER] = 1'b1;
      if (rxPush && rxCount == (RAW+1)'(RX_DEPTH - 1)) next_events[EV_RX_FULL] = 1'b1;
      if (cmdWrite && !dropRead && txFull) next_events[EV_TX_OVER] = 1'b1;
      if (txPop && txCount == (TAW+1)'(1) && !txPush) next_events[EV_TX_EMPTY] = 1'b1;
      if (slaveReadReq && !readReqSeen) next_events[EV_READ_REQ] = 1'b1;
      if (dropRead || gcAbort) next_events[EV_TX_ABORT] = 1'b1; // [R9] [R10] [R11]
      if (seq == SEQ_WAIT && opDone && busOp.code == OP_STOP) next_events[EV_STOP_DONE] = 1'b1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         events <= EVENT_RESET;
      end else begin
         events <= next_events;
      end
   end

   // built from next_events so that irq rises together with its status bit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_events & mask);
      end
   end

   // writes land at the edge that launches ack, a cycle before the master samples it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         mask <= MASK_RESET;
      end else if (wrAccess && wb_sel_i[0]) begin
         if (wb_adr_i == CTRL_ADDR) ctrl <= wb_dat_i[2:0];
         if (wb_adr_i == MASK_ADDR) mask <= wb_dat_i[7:0];
      end
   end

   // state register is read-only; a write to it is acked and ignored
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         DATA_CMD_ADDR: next_rdata = {24'h000000, rxAvail ? rxMem[rxRd] : 8'h00}; // [R15] [R16]
         CTRL_ADDR:     next_rdata = {29'h0000_0000, ctrl};
         EVENT_ADDR:    next_rdata = {24'h000000, events};
         MASK_ADDR:     next_rdata = {24'h000000, mask};
         STATE_ADDR: begin
            next_rdata[ST_ACTIVE_BIT]                 = active;
            next_rdata[ST_STALL_BIT]                  = sclHold;
            next_rdata[ST_TXLVL_LSB +: TAW+1]         = txCount;
            next_rdata[ST_RXLVL_LSB +: RAW+1]         = rxCount;
         end
         default:       next_rdata = 32'h0000_0000;
      endcase
   end

   // ack falls after one cycle, so a request still held is not taken twice
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= busReq;
         wb_dat_o <= rdAccess ? next_rdata : 32'h0000_0000;
      end
   end

endmodule : idcp_data_command_port

// File: tb/idcp_data_command_port_properties.sv
`timescale 1ns/1ps
module idcp_data_command_port_properties
   import idcp_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq,
   input wire idcp_busop_t busOp,
   input wire logic        opDone,
   input wire logic [7:0]  opRxByte,
   input wire logic        sclHold,
   input wire logic        slaveReadReq,
   input wire logic        slaveTxValid,
   input wire logic [7:0]  slaveTxData,
   input wire logic        slaveTxTaken,
   input wire logic        slaveRxValid,
   input wire logic [7:0]  slaveRxByte
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("ack without request");
   a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   a_upper_bits_zero: assert property (
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == DATA_CMD_ADDR |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper command bits not zero");
   a_op_held_open: assert property (
      busOp.valid && !opDone |=> busOp.valid && $stable(busOp)) else $error("bus op changed before done");
   a_stall_until_cmd: assert property (sclHold && !wb_cyc_i |=> sclHold)
      else $error("clock stretch ended without a command");
   a_tx_offer_held: assert property (
      slaveTxValid && !slaveTxTaken |=> slaveTxValid && $stable(slaveTxData)) else $error("offered byte lost");
   a_tx_gap_pop: assert property (slaveTxValid && slaveTxTaken |=> !slaveTxValid)
      else $error("offer not dropped after pop");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !busOp.valid && !wb_ack_o && !sclHold)
      else $error("outputs active in reset");
   c_read_done: cover property (busOp.valid && opDone && busOp.code == OP_READ);
   c_stall: cover property ($rose(sclHold));
   c_slave_pop: cover property (slaveTxValid && slaveTxTaken);
endmodule : idcp_data_command_port_properties

bind idcp_data_command_port idcp_data_command_port_properties chk (.clock(clock), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .busOp(busOp), .opDone(opDone),
   .opRxByte(opRxByte), .sclHold(sclHold), .slaveReadReq(slaveReadReq), .slaveTxValid(slaveTxValid),
   .slaveTxData(slaveTxData), .slaveTxTaken(slaveTxTaken), .slaveRxValid(slaveRxValid), .slaveRxByte(slaveRxByte));

// File: tb/idcp_bit_engine_model.sv
`timescale 1ns/1ps
module idcp_bit_engine_model
   import idcp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire idcp_busop_t busOp,
   input  wire logic        slowMode,
   output      logic        opDone,
   output      logic [7:0]  opRxByte
);
   logic [3:0] waitCount;
   logic       coolDown;
   logic [7:0] nextByte;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         opDone <= 1'b0;
         waitCount <= 4'h0;
         coolDown <= 1'b0;
         opRxByte <= 8'h00;
         nextByte <= 8'ha0;
      end else begin
         opDone <= 1'b0;
         // byte only meaningful with done: scramble it otherwise
         opRxByte <= ~opRxByte;
         if (coolDown) begin
            // skip the cycle in which the old op may still be shown
            coolDown <= 1'b0;
            waitCount <= 4'h0;
         end else if (busOp.valid) begin
            if (waitCount >= (slowMode ? 4'h6 : 4'h1)) begin
               opDone <= 1'b1;
               coolDown <= 1'b1;
               if (busOp.code == OP_READ) begin
                  opRxByte <= nextByte;
                  nextByte <= nextByte + 8'h11;
               end
            end else begin
               waitCount <= waitCount + 4'h1;
            end
         end
      end
   end
endmodule : idcp_bit_engine_model

// File: tb/idcp_data_command_port_bench.sv
`timescale 1ns/1ps
module idcp_data_command_port_bench;
   import idcp_pkg::*;
   logic        clock, rst_n, wbCyc, wbStb, wbWe, wbAck, irq, opDone, sclHold, slowMode;
   logic        slaveReadReq, slaveTxValid, slaveTxTaken, slaveRxValid, isOpen, lastRd;
   logic [31:0] wbAdr, wbDatW, wbDatR, rdata, seed;
   logic [3:0]  wbSel;
   logic [7:0]  opRxByte, slaveTxData, slaveRxByte, rxNext, b;
   idcp_busop_t busOp;
   logic [11:0] opLog[$], expOps[$];
   logic [7:0]  expRx[$];
   int          numErrors, totalChecks, r, n;
   idcp_data_command_port uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq(irq),
      .busOp(busOp), .opDone(opDone), .opRxByte(opRxByte), .sclHold(sclHold), .slaveReadReq(slaveReadReq),
      .slaveTxValid(slaveTxValid), .slaveTxData(slaveTxData), .slaveTxTaken(slaveTxTaken),
      .slaveRxValid(slaveRxValid), .slaveRxByte(slaveRxByte));
   idcp_bit_engine_model engine (.clock(clock), .rst_n(rst_n), .busOp(busOp), .slowMode(slowMode),
      .opDone(opDone), .opRxByte(opRxByte));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // only writes carry a byte; a read's byte field must never reach the engine
   always @(posedge clock) if (rst_n && busOp.valid && opDone)
      opLog.push_back({busOp.code, busOp.data});
   task automatic endOfTest;
      if (numErrors == 0 && totalChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : endOfTest
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tick(inout int cnt);
      @(posedge clock);
      cnt++;
      if (cnt > 600) begin
         numErrors++;
         endOfTest();
      end
   endtask : tick
   task automatic wbXfer(input logic we, input logic [31:0] adr, input logic [31:0] dat);
      int cnt;
      cnt = 0;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      wbSel <= 4'hf;
      do tick(cnt); while (wbAck !== 1'b1);
      rdata = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wbXfer
   task automatic rdCheck(input logic [31:0] adr, input logic [31:0] exp, input string what);
      wbXfer(1'b0, adr, 32'h0);
      check(what, exp, rdata);
   endtask : rdCheck
   task automatic rdBit(input logic [31:0] adr, input int pos, input logic exp, input string what);
      wbXfer(1'b0, adr, 32'h0);
      check(what, {31'h0, exp}, {31'h0, rdata[pos]});
   endtask : rdBit
   task automatic waitIrq(input logic lvl);
      int cnt;
      cnt = 0;
      while (irq !== lvl) tick(cnt);
   endtask : waitIrq
   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction : rnd
   function automatic void addOp(input idcp_op_t c, input logic [7:0] d);
      expOps.push_back({c, c == OP_WRITE ? d : 8'h00});
   endfunction : addOp
   // expected bus ops follow from restart, stop, direction and the repeated start control
   task automatic sendCmd(input logic rs, input logic sp, input logic rd, input logic allow);
      logic [7:0] d;
      d = rnd();
      if (!isOpen) addOp(OP_START, 8'h00);
      else if (rs || rd != lastRd) begin
         if (allow) addOp(OP_RESTART, 8'h00);
         else begin
            addOp(OP_STOP, 8'h00);
            addOp(OP_START, 8'h00);
         end
      end
      addOp(rd ? OP_READ : OP_WRITE, d);
      if (rd) expRx.push_back(rxNext);
      if (rd) rxNext = rxNext + 8'h11;
      if (sp) addOp(OP_STOP, 8'h00);
      isOpen = !sp;
      lastRd = rd;
      wbXfer(1'b1, DATA_CMD_ADDR, {21'h0, rs, sp, rd, d});
   endtask : sendCmd
   task automatic flushOps;
      int cnt;
      cnt = 0;
      while (opLog.size() < expOps.size()) tick(cnt);
      foreach (expOps[k]) check("bus op", 32'(expOps[k]), 32'(opLog[k]));
      expOps.delete();
      opLog.delete();
   endtask : flushOps
   initial begin
      seed = 32'he2dd;
      rxNext = 8'ha0;
      isOpen = 1'b0;
      lastRd = 1'b0;
      {rst_n, wbCyc, wbStb, wbWe, slowMode, slaveReadReq, slaveTxTaken, slaveRxValid} = 8'h00;
      {wbAdr, wbDatW, wbSel, slaveRxByte} = 76'h0;
      numErrors = 0;
      totalChecks = 0;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rdCheck(CTRL_ADDR, {29'h0, CTRL_RESET}, "ctrl reset");
      rdCheck(MASK_ADDR, {24'h0, MASK_RESET}, "mask reset");
      rdCheck(STATE_ADDR, 32'h0, "state reset");
      rdCheck(32'h5000_1300, 32'h0, "unmapped read");
      rdCheck(DATA_CMD_ADDR, {16'h0, DATA_CMD_RESET}, "empty command read");
      wbXfer(1'b1, EVENT_ADDR, 32'hff);
      for (r = 0; r < 2; r++) begin
         slowMode <= r[0];
         wbXfer(1'b1, CTRL_ADDR, {30'h0, 1'b1, r == 0});
         sendCmd(1'b0, 1'b0, 1'b0, r == 0);
         sendCmd(1'b0, 1'b0, 1'b1, r == 0);
         sendCmd(1'b1, 1'b1, 1'b1, r == 0);
         sendCmd(1'b0, 1'b0, 1'b0, r == 0);
         n = 0;
         while (sclHold !== 1'b1) tick(n);
         rdBit(STATE_ADDR, ST_STALL_BIT, 1'b1, "stall flag");
         sendCmd(1'b0, 1'b1, 1'b0, r == 0);
         flushOps();
         rdBit(STATE_ADDR, ST_STALL_BIT, 1'b0, "stall after stop");
      end
      foreach (expRx[k]) rdCheck(DATA_CMD_ADDR, {24'h0, expRx[k]}, "rx byte");
      rdCheck(DATA_CMD_ADDR, 32'h0, "empty rx read");
      rdBit(EVENT_ADDR, EV_RX_UNDER, 1'b1, "rx underflow");
      wbXfer(1'b1, EVENT_ADDR, 32'hff);
      wbXfer(1'b1, MASK_ADDR, 32'h1 << EV_TX_ABORT);
      slaveReadReq <= 1'b1;
      wbXfer(1'b1, DATA_CMD_ADDR, {21'h0, 3'b001, rnd()});
      waitIrq(1'b1);
      rdBit(EVENT_ADDR, EV_TX_ABORT, 1'b1, "abort flag");
      rdBit(STATE_ADDR, ST_TXLVL_LSB, 1'b0, "tx level");
      check("ops issued", 32'h0, 32'(opLog.size()));
      wbXfer(1'b1, MASK_ADDR, 32'h0);
      waitIrq(1'b0);
      wbXfer(1'b1, MASK_ADDR, 32'h1 << EV_TX_ABORT);
      waitIrq(1'b1);
      wbXfer(1'b1, EVENT_ADDR, 32'h1 << EV_TX_ABORT);
      waitIrq(1'b0);
      wbXfer(1'b1, CTRL_ADDR, 32'h1);
      b = rnd();
      wbXfer(1'b1, DATA_CMD_ADDR, {21'h0, 3'b000, b});
      n = 0;
      while (slaveTxValid !== 1'b1) tick(n);
      check("slave tx byte", {24'h0, b}, {24'h0, slaveTxData});
      slaveTxTaken <= 1'b1;
      @(posedge clock);
      slaveTxTaken <= 1'b0;
      slaveReadReq <= 1'b0;
      b = rnd();
      slaveRxByte <= b;
      slaveRxValid <= 1'b1;
      @(posedge clock);
      slaveRxValid <= 1'b0;
      rdCheck(DATA_CMD_ADDR, {24'h0, b}, "slave rx byte");
      wbXfer(1'b1, EVENT_ADDR, 32'hff);
      wbXfer(1'b1, CTRL_ADDR, 32'h7);
      wbXfer(1'b1, DATA_CMD_ADDR, {21'h0, 3'b011, rnd()});
      waitIrq(1'b1);
      rdBit(EVENT_ADDR, EV_TX_ABORT, 1'b1, "general call abort");
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      check("irq in reset", 32'h0, {31'h0, irq});
      rdCheck(CTRL_ADDR, {29'h0, CTRL_RESET}, "ctrl after reset");
      rdCheck(EVENT_ADDR, {24'h0, EVENT_RESET}, "events after reset");
      rdCheck(STATE_ADDR, 32'h0, "state after reset");
      endOfTest();
   end
endmodule : idcp_data_command_port_bench
